// File: hw/dcp_core.v
// command phase sequencer and parameter decoder of the disk controller
`timescale 1ns/1ps
`include "dcp_map.vh"
module dcp_core #(
  parameter MS_CYC = `DCP_MS_CYC,
  parameter TURN_CYC = `DCP_TURN_CYC
) (
  input wire clock_i,
  input wire arst_n_i,
  input wire cs_n_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire data_sel_i,
  input wire [7:0] data_i,
  output reg [7:0] data_o,
  output wire data_oe_o,
  output reg int_o,
  input wire non_dma_i,
  input wire drive_byte_i,
  input wire [7:0] drive_data_i,
  input wire exec_done_i,
  input wire [7:0] exec_st0_i,
  input wire [7:0] exec_st1_i,
  input wire [7:0] exec_st2_i,
  input wire [3:0] drive_busy_i,
  output reg [1:0] drive_select_lines_o,
  output reg head_select_bit_o,
  output reg density_select_o,
  output reg multitrack_enable_o,
  output reg [7:0] cylinder_o,
  output reg cylinder_bad_o,
  output reg [7:0] record_o,
  output reg [7:0] size_code_o,
  output reg [7:0] final_sector_number_o,
  output reg [7:0] gap_three_length_o,
  output reg [7:0] transfer_length_limit_o,
  output reg [15:0] sector_bytes_o,
  output reg [1:0] scan_sector_stride_o,
  output reg [31:0] head_settle_cyc_o,
  output reg [31:0] head_release_cyc_o,
  output reg [31:0] step_cyc_o,
  output reg exec_start_o,
  output reg exec_active_o
);
  // ****************************************
  // strobe synchronisation
  // ****************************************
  // strobes are qualified by chip select before synchronising; select
  // and data are levels; data is only looked at once a strobe is seen, select also by the output byte mux in every cycle without a read strobe
  wire rd_s;
  wire wr_s;
  reg rd_d;
  reg wr_d;
  dcp_sync u_rd (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .async_i(~rd_n_i & ~cs_n_i), .sync_o(rd_s));
  dcp_sync u_wr (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .async_i(~wr_n_i & ~cs_n_i), .sync_o(wr_s));
  wire rd_rise = rd_s & ~rd_d;
  wire wr_rise = wr_s & ~wr_d;
  // ****************************************
  // state and storage
  // ****************************************
  localparam S_IDLE = 4'b0001;
  localparam S_CMD = 4'b0010;
  localparam S_EXEC = 4'b0100;
  localparam S_RES = 4'b1000;
  reg [3:0] state;
  // cmd holds the raw bytes; the decode reads them only at the start
  // pulse, so a half-written next command never leaks to the outputs
  reg [7:0] cmd [0:8];
  reg [7:0] res [0:6];
  reg [3:0] idx;
  reg [3:0] need;
  reg [3:0] res_need;
  reg req;
  reg [15:0] turn;
  reg [7:0] rx_byte;
  reg rx_full;
  reg dir;
  // command bytes expected for an opcode
  function [3:0] cmd_len;
    input [4:0] op;
    begin
      case (op)
        5'h03: cmd_len = 4'd3;
        5'h04: cmd_len = 4'd2;
        5'h07: cmd_len = 4'd2;
        5'h08: cmd_len = 4'd1;
        5'h0f: cmd_len = 4'd3;
        5'h0d: cmd_len = 4'd6;
        5'h0a: cmd_len = 4'd2;
        default: cmd_len = `DCP_CMD_BYTES;
      endcase
    end
  endfunction
  // result bytes returned for an opcode
  function [3:0] res_len;
    input [4:0] op;
    begin
      case (op)
        // seek and recalibrate have no result; sense interrupt reports
        5'h03: res_len = 4'd0;
        5'h0f: res_len = 4'd0;
        5'h07: res_len = 4'd0;
        5'h04: res_len = 4'd1;
        5'h08: res_len = 4'd2;
        default: res_len = `DCP_RES_BYTES;
      endcase
    end
  endfunction
  // opcodes that are recognised
  function known;
    input [4:0] op;
    begin
      case (op)
        5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
        5'h0a, 5'h0c, 5'h0d, 5'h0f, 5'h11, 5'h19, 5'h1d: known = 1'b1;
        // anything else answers with the invalid status byte
        default: known = 1'b0;
      endcase
    end
  endfunction
  // ****************************************
  // host side bus
  // ****************************************
  // direction bit shows transfer way
  wire [7:0] msr = {req, dir, exec_active_o & non_dma_i,
    state != S_IDLE, drive_busy_i};
  assign data_oe_o = ~cs_n_i & ~rd_n_i;
  // output byte is registered; sampled from live state each cycle without a read strobe
  // select routes status or data
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_o <= 8'h00;
    end else if (rd_s) begin
      // frozen under the read strobe, because the result index moves on
      // at the strobe's start and the host must still see the old byte
      data_o <= data_o;
    end else if (!data_sel_i) begin
      data_o <= msr;
    end else if (state == S_RES) begin
      data_o <= res[idx[2:0]];
    end else begin
      data_o <= rx_byte;
    end
  end
  // ****************************************
  // phase sequencer
  // ****************************************
  // phases advance idle, command, execute, result
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= S_IDLE;
      idx <= 4'h0;
      need <= 4'h0;
      res_need <= 4'h0;
      req <= 1'b1;
      dir <= 1'b0;
      turn <= 16'h0000;
      rd_d <= 1'b0;
      wr_d <= 1'b0;
      int_o <= 1'b0;
      rx_byte <= 8'h00;
      rx_full <= 1'b0;
      exec_start_o <= 1'b0;
      exec_active_o <= 1'b0;
      cmd[0] <= 8'h00; cmd[1] <= 8'h00; cmd[2] <= 8'h00;
      cmd[3] <= 8'h00; cmd[4] <= 8'h00; cmd[5] <= 8'h00;
      cmd[6] <= 8'h00; cmd[7] <= 8'h00; cmd[8] <= 8'h00;
      res[0] <= 8'h00; res[1] <= 8'h00; res[2] <= 8'h00;
      res[3] <= 8'h00; res[4] <= 8'h00; res[5] <= 8'h00;
      res[6] <= 8'h00;
    end else begin
      rd_d <= rd_s;
      wr_d <= wr_s;
      exec_start_o <= 1'b0;
      // turn counts the quiet time after each host byte, long enough
      // for the host's own status poll to see the request low first
      // request returns after the turnaround
      if (turn != 16'h0000) begin
        turn <= turn - 16'h0001;
        if (turn == 16'h0001 && state != S_EXEC) begin
          req <= 1'b1;
        end
      end
      case (state)
        S_IDLE, S_CMD: begin
          // refused bytes are dropped silently; the status shows why
          // byte taken only with direction 0
          if (wr_rise && data_sel_i && req && !dir) begin
            cmd[idx] <= data_i;
            req <= 1'b0;
            turn <= TURN_CYC[15:0];
            if (state == S_IDLE && !known(data_i[4:0])) begin
              // unknown opcode answers one invalid status byte
              res[0] <= `DCP_INVALID_ST0;
              res_need <= 4'd1;
              idx <= 4'h0;
              dir <= 1'b1;
              state <= S_RES;
            end else if (state == S_IDLE) begin
              need <= cmd_len(data_i[4:0]);
              res_need <= res_len(data_i[4:0]);
              if (cmd_len(data_i[4:0]) == 4'd1) begin
                idx <= 4'h0;
                state <= S_EXEC;
                exec_start_o <= 1'b1;
                exec_active_o <= 1'b1;
              end else begin
                idx <= 4'h1;
                state <= S_CMD;
              end
            end else if (idx + 4'h1 == need) begin
              idx <= 4'h0;
              state <= S_EXEC;
              exec_start_o <= 1'b1;
              exec_active_o <= 1'b1;
            end else begin
              idx <= idx + 4'h1;
            end
          end
        end
        S_EXEC: begin
          // request stays low until a drive byte is there to be taken
          // each drive byte in non-dma mode raises the interrupt
          if (non_dma_i && drive_byte_i) begin
            rx_byte <= drive_data_i;
            rx_full <= 1'b1;
            int_o <= 1'b1;
            req <= 1'b1;
            dir <= 1'b1;
          end else if (rx_full && data_sel_i && (rd_rise || wr_rise)) begin
            // the data strobe takes the byte; request returns only with
            // the next one or at termination, so a polling host cannot take it twice
            int_o <= 1'b0;
            rx_full <= 1'b0;
            req <= 1'b0;
          end
          if (exec_done_i) begin
            res[0] <= exec_st0_i;
            res[1] <= exec_st1_i;
            res[2] <= exec_st2_i;
            res[3] <= cylinder_o;
            res[4] <= {7'h00, head_select_bit_o};
            res[5] <= record_o;
            res[6] <= size_code_o;
            exec_active_o <= 1'b0;
            // a byte the host never took is dropped with the command
            rx_full <= 1'b0;
            idx <= 4'h0;
            // termination raises the interrupt for the result phase
            int_o <= (res_need != 4'h0);
            if (res_need == 4'h0) begin
              state <= S_IDLE;
              req <= 1'b1;
              dir <= 1'b0;
            end else begin
              state <= S_RES;
              req <= 1'b1;
              dir <= 1'b1;
            end
          end
        end
        S_RES: begin
          // result byte leaves with direction and request 1
          if (rd_rise && data_sel_i && req && dir) begin
            int_o <= 1'b0;
            req <= 1'b0;
            turn <= TURN_CYC[15:0];
            if (idx + 4'h1 == res_need) begin
              idx <= 4'h0;
              dir <= 1'b0;
              state <= S_IDLE;
            end else begin
              idx <= idx + 4'h1;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // ****************************************
  // parameter decode
  // ****************************************
  // fields are decoded once execution starts; held until the next one
  // specify only touches the timing outputs and leaves the rest alone
  // timing products are 32 bits; the longest settle count still fits
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drive_select_lines_o <= 2'b00;
      head_select_bit_o <= 1'b0;
      density_select_o <= 1'b0;
      multitrack_enable_o <= 1'b0;
      cylinder_o <= 8'h00;
      cylinder_bad_o <= 1'b0;
      record_o <= 8'h00;
      size_code_o <= 8'h00;
      final_sector_number_o <= 8'h00;
      gap_three_length_o <= 8'h00;
      transfer_length_limit_o <= 8'h00;
      sector_bytes_o <= 16'h0000;
      scan_sector_stride_o <= 2'b01;
      head_settle_cyc_o <= 32'h00000000;
      head_release_cyc_o <= 32'h00000000;
      step_cyc_o <= 32'h00000000;
    end else if (exec_start_o && cmd[0][4:0] == 5'h03) begin
      step_cyc_o <= (32'h00000010 - {28'h0, cmd[1][7:4]}) * MS_CYC;
      // release delay in 16 ms units
      head_release_cyc_o <= {28'h0, cmd[1][3:0]} *
        `DCP_RELEASE_STEP_MS * MS_CYC;
      // settle delay in 2 ms units
      head_settle_cyc_o <= {25'h0, cmd[2][7:1]} *
        `DCP_SETTLE_STEP_MS * MS_CYC;
    end else if (exec_start_o) begin
      drive_select_lines_o <= cmd[1][1:0];
      head_select_bit_o <= cmd[1][2];
      // density bit low fm high mfm
      density_select_o <= cmd[0][6];
      // multitrack flag for side 1 continuation
      multitrack_enable_o <= cmd[0][7];
      cylinder_o <= cmd[2];
      cylinder_bad_o <= (cmd[2] > `DCP_MAX_CYL);
      record_o <= cmd[4];
      size_code_o <= cmd[5];
      final_sector_number_o <= cmd[6];
      // gap length for sync low time
      gap_three_length_o <= cmd[7];
      // length limit only for size code 00
      transfer_length_limit_o <= cmd[8];
      sector_bytes_o <= (cmd[5] == 8'h00) ? {8'h00, cmd[8]} :
        (16'h0080 << cmd[5][2:0]);
      scan_sector_stride_o <= (cmd[8] == 8'h02) ? 2'b10 : 2'b01;
    end
  end
endmodule

// File: hw/dcp_sync.v
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module dcp_sync (
  input wire clock_i,
  input wire arst_n_i,
  input wire async_i,
  output reg sync_o
);
  reg s1;
  reg s2;
  reg s3;
  // first flop only feeds the second
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_o <= s3;
      end
    end
  end
endmodule

// File: inc/dcp_map.vh
// constants for the disk controller command protocol block
// What this block does
// - command, execution, result phases in order
// - write allowed when direction 0, request 1
// - result read when direction and request 1
// - non-dma read raises interrupt per byte
// - select low status, high data register
// - cylinder values 0 through 76
// - length limit used only when size 00
// - stop after final sector number
// - gap length sets sync low bytes
// - head bit drives side select polarity
// - head settle 2 to 254 ms, step 2
// - head release 16 to 240 ms, step 16
// - density low fm, high mfm
// - multitrack continues to side 1 sector 1
// - step interval inverse, f is 1 ms
// - scan stride 1 contiguous, 2 alternate
// - nine command bytes, seven result bytes
// - direction 1 means device to host
// - auto execute after last byte, end after result
`ifndef DCP_MAP_VH
`define DCP_MAP_VH
// main status bit positions
`define DCP_MSR_BUSY 4
`define DCP_MSR_EXEC 5
`define DCP_MSR_DIR 6
`define DCP_MSR_REQ 7
// command and result byte counts, highest cylinder
`define DCP_CMD_BYTES 4'd9
`define DCP_RES_BYTES 4'd7
`define DCP_MAX_CYL 8'h4c
// byte turnaround time in ns and derived cycles
`define DCP_CLK_NS 10
`define DCP_TURN_NS 2000
`define DCP_TURN_CYC (`DCP_TURN_NS / `DCP_CLK_NS)
// timing units in ms and cycles per ms
`define DCP_MS_NS 1000000
`define DCP_MS_CYC (`DCP_MS_NS / `DCP_CLK_NS)
`define DCP_SETTLE_STEP_MS 2
`define DCP_RELEASE_STEP_MS 16
`define DCP_INVALID_ST0 8'h80
`endif

// File: tb/dcp_core_props.sv
// concurrent checks on the command core ports
`timescale 1ns/1ps
module dcp_core_props #(
  parameter MS_CYC = 10
) (
  input wire clock_i,
  input wire arst_n_i,
  input wire cs_n_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire data_sel_i,
  input wire [7:0] data_i,
  input wire non_dma_i,
  input wire drive_byte_i,
  input wire exec_done_i,
  input wire data_oe_o,
  input wire int_o,
  input wire exec_start_o,
  input wire exec_active_o,
  input wire [7:0] cylinder_o,
  input wire cylinder_bad_o,
  input wire [7:0] size_code_o,
  input wire [7:0] transfer_length_limit_o,
  input wire [15:0] sector_bytes_o,
  input wire [1:0] scan_sector_stride_o,
  input wire [31:0] step_cyc_o,
  input wire [31:0] head_release_cyc_o
);
  // ****************
  // opcode capture
  // ****************
  // the first data write after a finished command is its opcode;
  // commands with no result bytes end without an interrupt
  reg wr_q;
  reg op_open;
  reg [4:0] op;
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q <= 1'b0;
      op_open <= 1'b1;
      op <= 5'h00;
    end else begin
      wr_q <= !cs_n_i && !wr_n_i;
      if (!cs_n_i && !wr_n_i && !wr_q && data_sel_i && op_open) begin
        op <= data_i[4:0];
        op_open <= 1'b0;
      end
      // result reads re-arm it too, which covers a refused opcode
      if ((exec_active_o && exec_done_i) ||
        (!exec_active_o && !cs_n_i && !rd_n_i && data_sel_i)) begin
        op_open <= 1'b1;
      end
    end
  end
  // ****************
  // properties
  // ****************
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);
  start_pulse_a: assert property (exec_start_o |=> !exec_start_o)
    else $error("execution start wider than one cycle");
  exec_enter_a: assert property (exec_start_o |-> ##[0:1] exec_active_o)
    else $error("execution did not follow the last command byte");
  read_drive_a: assert property (data_oe_o == (!cs_n_i && !rd_n_i))
    else $error("bus drive does not follow the read strobe");
  cyl_range_a: assert property (cylinder_bad_o == (cylinder_o > 8'h4c))
    else $error("cylinder range flag wrong");
  length_use_a: assert property (size_code_o < 8'h08 |->
    sector_bytes_o == ((size_code_o == 8'h00) ?
    {8'h00, transfer_length_limit_o} : (16'h0080 << size_code_o)))
    else $error("sector byte count wrong");
  step_range_a: assert property (step_cyc_o == 0 ||
    (step_cyc_o % MS_CYC == 0 && step_cyc_o <= 16 * MS_CYC))
    else $error("step interval off the 1 ms grid");
  release_range_a: assert property (head_release_cyc_o == 0 ||
    (head_release_cyc_o % (16 * MS_CYC) == 0 &&
    head_release_cyc_o <= 240 * MS_CYC))
    else $error("head release off the 16 ms grid");
  stride_val_a: assert property (scan_sector_stride_o inside {2'd1, 2'd2})
    else $error("scan stride outside 1 and 2");
  int_clear_a: assert property ((!cs_n_i && !rd_n_i && data_sel_i) [*8]
    |-> !int_o)
    else $error("interrupt survived a data read");
  done_int_a: assert property (exec_active_o && exec_done_i &&
    !(op inside {5'h03, 5'h07, 5'h0f}) |-> ##[1:3] int_o)
    else $error("no interrupt at end of execution");
  quiet_end_a: assert property (exec_active_o && exec_done_i &&
    (op inside {5'h03, 5'h07, 5'h0f}) |=> !int_o)
    else $error("interrupt after a command with no results");
  byte_int_a: assert property (exec_active_o && non_dma_i && drive_byte_i
    |-> ##[1:3] int_o)
    else $error("no interrupt for a drive byte");
endmodule
bind dcp_core dcp_core_props #(.MS_CYC(MS_CYC)) dcp_core_props_i (
  .clock_i(clock_i),
  .arst_n_i(arst_n_i),
  .cs_n_i(cs_n_i),
  .rd_n_i(rd_n_i),
  .wr_n_i(wr_n_i),
  .data_sel_i(data_sel_i),
  .data_i(data_i),
  .non_dma_i(non_dma_i),
  .drive_byte_i(drive_byte_i),
  .exec_done_i(exec_done_i),
  .data_oe_o(data_oe_o),
  .int_o(int_o),
  .exec_start_o(exec_start_o),
  .exec_active_o(exec_active_o),
  .cylinder_o(cylinder_o),
  .cylinder_bad_o(cylinder_bad_o),
  .size_code_o(size_code_o),
  .transfer_length_limit_o(transfer_length_limit_o),
  .sector_bytes_o(sector_bytes_o),
  .scan_sector_stride_o(scan_sector_stride_o),
  .step_cyc_o(step_cyc_o),
  .head_release_cyc_o(head_release_cyc_o)
);

// File: tb/dcp_drive_model.sv
// execution-side stand-in: one drive byte in non-dma mode, then termination
`timescale 1ns/1ps
module dcp_drive_model (
  input wire clock_i,
  input wire start_i,
  input wire byte_en_i,
  output reg drive_byte_o,
  output reg [7:0] drive_data_o,
  output reg exec_done_o
);
  initial begin
    drive_byte_o = 1'b0;
    drive_data_o = 8'h5a;
    exec_done_o = 1'b0;
  end
  // byte first, termination long after so the host can take it
  always @(posedge clock_i) begin
    if (start_i) begin
      repeat (30) @(posedge clock_i);
      if (byte_en_i) begin
        drive_byte_o <= 1'b1;
        drive_data_o <= 8'ha5;
        @(posedge clock_i);
        drive_byte_o <= 1'b0;
        drive_data_o <= 8'h5a; // idle value differs from the last byte
      end
      repeat (150) @(posedge clock_i);
      exec_done_o <= 1'b1;
      @(posedge clock_i);
      exec_done_o <= 1'b0;
    end
  end
endmodule

// File: tb/test_disk_ctrl_command_protocol.sv
// self-checking bench for the disk controller command core
`timescale 1ns/1ps
module test_disk_ctrl_command_protocol;
  localparam MS = 10;
  localparam GAP = 1200; // 12 us host pause before each status poll
  reg clock_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg cs_n_i = 1'b1, rd_n_i = 1'b1, wr_n_i = 1'b1, data_sel_i = 1'b0;
  reg non_dma_i = 1'b1;
  reg [7:0] data_i = 8'h00, q;
  reg [7:0] sa = 8'h06, sb = 8'h80, sc = 8'h02;
  reg [7:0] cmd [0:8];
  wire [7:0] data_o, ddat, fin, gap;
  wire [15:0] secb;
  wire [31:0] stc, hsc, hrc;
  wire [1:0] dsl, stride;
  wire int_o, start, active, dbyte, done, head, dens, mt, cbad;
  int n_errors = 0, samples_checked = 0;
  always #5 clock_i = ~clock_i;
  dcp_core #(.MS_CYC(MS), .TURN_CYC(4)) dcp_core_i (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
    .data_sel_i(data_sel_i), .data_i(data_i), .data_o(data_o),
    .data_oe_o(), .int_o(int_o), .non_dma_i(non_dma_i),
    .drive_byte_i(dbyte), .drive_data_i(ddat), .exec_done_i(done),
    .exec_st0_i(sa), .exec_st1_i(sb), .exec_st2_i(sc), .drive_busy_i(4'h0),
    .drive_select_lines_o(dsl), .head_select_bit_o(head),
    .density_select_o(dens), .multitrack_enable_o(mt), .cylinder_o(),
    .cylinder_bad_o(cbad), .record_o(), .size_code_o(),
    .final_sector_number_o(fin), .gap_three_length_o(gap),
    .transfer_length_limit_o(), .sector_bytes_o(secb),
    .scan_sector_stride_o(stride), .head_settle_cyc_o(hsc),
    .head_release_cyc_o(hrc), .step_cyc_o(stc), .exec_start_o(start),
    .exec_active_o(active));
  dcp_drive_model dcp_drive_model_i (.clock_i(clock_i), .start_i(start),
    .byte_en_i(non_dma_i), .drive_byte_o(dbyte), .drive_data_o(ddat),
    .exec_done_o(done));
  // ****************
  // host access tasks
  // ****************
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobe held long enough to pass the input synchroniser
  task strobe(input sel, input wr, input [7:0] d);
    @(posedge clock_i);
    data_sel_i <= sel;
    data_i <= d;
    cs_n_i <= 1'b0;
    wr_n_i <= !wr;
    rd_n_i <= wr;
    repeat (8) @(posedge clock_i);
    q = data_o;
    cs_n_i <= 1'b1;
    wr_n_i <= 1'b1;
    rd_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
  endtask
  task poll(input [7:0] mask, input [7:0] want);
    int i;
    repeat (GAP) @(posedge clock_i);
    for (i = 0; i < 60; i++) begin
      strobe(1'b0, 1'b0, 8'h00);
      if ((q & mask) == want) break;
    end
    chk(q & mask, want);
  endtask
  task put(input [7:0] d);
    poll(8'hc0, 8'h80);
    strobe(1'b1, 1'b1, d);
  endtask
  task get(input [7:0] exp);
    poll(8'hc0, 8'hc0);
    strobe(1'b1, 1'b0, 8'h00);
    chk(q, exp);
  endtask
  task send9;
    int i;
    for (i = 0; i < 9; i++) put(cmd[i]);
  endtask
  task results(input [7:0] c, input [7:0] h, input [7:0] r, input [7:0] n);
    get(sa);
    get(sb);
    get(sc);
    get(c);
    get(h);
    get(r);
    get(n);
    poll(8'hff, 8'h80);
  endtask
  task wait_int;
    int i;
    for (i = 0; i < 400 && int_o !== 1'b1; i++) @(posedge clock_i);
    chk(int_o, 1'b1);
  endtask
  task conclude;
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    repeat (10) @(posedge clock_i);
    arst_n_i <= 1'b1;
    strobe(1'b0, 1'b0, 8'h00);
    chk(q, 8'h80);
    chk(stride, 2'd1);
    $display("test reset done");
    put(8'h03);
    put(8'he3);
    put(8'h0b);
    poll(8'hff, 8'h80);
    chk(stc, 2 * MS);
    chk(hsc, 10 * MS);
    chk(hrc, 48 * MS);
    $display("test timing done");
    // multitrack mfm read, head 1, drive 2, cylinder one past the last
    cmd = '{8'hc6, 8'h06, 8'h4d, 8'h01, 8'h03, 8'h00, 8'h09, 8'h1b, 8'h40};
    send9;
    wait_int;
    strobe(1'b0, 1'b0, 8'h00);
    chk(q[5], 1'b1);
    strobe(1'b1, 1'b0, 8'h00);
    chk(int_o, 1'b0);
    chk(q, 8'ha5);
    chk({dsl, head, dens, mt, cbad}, 6'b101111);
    chk({fin, gap}, 16'h091b);
    chk(secb, 16'h0040);
    wait_int;
    results(8'h4d, 8'h01, 8'h03, 8'h00);
    $display("test read done");
    // dma scan at the last valid cylinder, stride of two
    non_dma_i <= 1'b0;
    cmd = '{8'hd1, 8'h00, 8'h4c, 8'h00, 8'h01, 8'h01, 8'h05, 8'h0e, 8'h02};
    send9;
    wait_int;
    chk(stride, 2'd2);
    chk({dsl, head, dens, mt, cbad}, 6'b000110);
    chk(secb, 16'h0100);
    results(8'h4c, 8'h00, 8'h01, 8'h01);
    $display("test scan done");
    put(8'h1f);
    get(8'h80);
    poll(8'hff, 8'h80);
    $display("test invalid done");
    conclude;
  end
  // hang guard at about twice the expected run
  initial begin
    #1000000;
    n_errors++;
    conclude;
  end
endmodule
